// ==== rtl/mic_pkg.sv ====
// Purpose: Shared constants and types of the interrupt controller.
// Assumes: 8-bit registers on a plain strobe port, one clock domain.
// Notes:   Source index order doubles as fixed service priority.

package mic_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NEXT  = 4;
  localparam int NCMP  = 2;
  localparam int NGRP  = 5;
  localparam int NUART = 3;
  localparam int NSRC  = NEXT + NCMP + 1 + NGRP;
  localparam int SW    = 4;
  localparam int AW    = 4;
  localparam int DW    = 8;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [AW-1:0] ADDR_CTRL = 4'h0;
  localparam logic [AW-1:0] ADDR_EXT  = 4'h1;
  localparam logic [AW-1:0] ADDR_EDGE = 4'h2;
  localparam logic [AW-1:0] ADDR_CMP  = 4'h3;
  localparam logic [AW-1:0] ADDR_GRPF = 4'h4;
  localparam logic [AW-1:0] ADDR_GRPE = 4'h5;
  localparam logic [AW-1:0] ADDR_UART = 4'h6;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_GIE_BIT  = 0;
  localparam int CTRL_FULL_BIT = 1;
  localparam int EXT_FLAG_LSB  = 4;
  localparam int EXT_EN_LSB    = 0;
  localparam int CMP_FLAG_LSB  = 4;
  localparam int CONV_FLAG_BIT = 6;
  localparam int CMP_EN_LSB    = 0;
  localparam int CONV_EN_BIT   = 2;
  localparam int UART_FLAG_LSB = 4;
  localparam int UART_EN_LSB   = 0;

  // ----------------------------------------
  // Source indices, lowest index serviced first
  // ----------------------------------------
  localparam int SRC_EXT    = 0;
  localparam int SRC_CMP    = 4;
  localparam int SRC_CONV   = 6;
  localparam int SRC_GRP    = 7;
  localparam int UART_GROUP = 4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [DW-1:0] RST_BYTE = 8'h00;
  localparam logic          RST_BIT  = 1'b0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MIC_EDGE_OFF  = 2'b00,
    MIC_EDGE_RISE = 2'b01,
    MIC_EDGE_FALL = 2'b10,
    MIC_EDGE_BOTH = 2'b11
  } mic_edge_type;

  typedef struct packed {
    logic          wr;
    logic          rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } mic_bus_req_type;

endpackage

// ==== rtl/mic_stack.sv ====
// Purpose: Return address stack shared by calls and interrupts.
// Assumes: Push and pop never in the same cycle.
// Notes:   Top of stack read combinationally for a same-cycle pop.

module mic_stack #(
  parameter int PC_W  = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            arst_n,
  // Stack access
  input  wire logic            push,
  input  wire logic            pop,
  input  wire logic [PC_W-1:0] push_data,
  output logic      [PC_W-1:0] top_data,
  output logic                 full
);

  localparam int PW = $clog2(DEPTH + 1);

  logic [PC_W-1:0] mem [DEPTH];
  logic [PW-1:0]   sp_r;

  // ----------------------------------------
  // Pointer
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sp_r <= '0;
    else if (push && !full)
      sp_r <= sp_r + PW'(1);
    else if (pop && sp_r != '0)
      sp_r <= sp_r - PW'(1);
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (push && !full)
      mem[sp_r[PW-1:0] % DEPTH] <= push_data;
  end

  // Empty stack pops as zero rather than stale data
  assign top_data = (sp_r == '0) ? '0 : mem[(sp_r - PW'(1)) % DEPTH];
  assign full     = (sp_r == PW'(DEPTH));

endmodule

// ==== rtl/mic_ctrl.sv ====
// Purpose: Interrupt controller: flags, enables, priority, vectoring.
// Assumes: Core pulses stack_push, stack_pop, return_from_interrupt_req one at a time.
// Notes:   Vector table and priority fixed by parameters and index order.
//
// Summary of operation
// R1 - UART flags in bits 6..4; bits 7 and 3 read zero.
// R2 - UART enables in bits 2..0; one enables the channel (the bits are only stored and read back, they gate no flag).
// R3 - A source condition sets its request flag.
// R4 - A set flag with its enable clear stays set, no vectoring.
// R5 - Global enable low means no interrupt is taken.
// R6 - Taking pushes next PC and loads the source vector.
// R7 - Return-from-interrupt pops the saved PC and resumes.
// R8 - Any taken interrupt clears the global enable.
// R9 - Requests while blocked keep their flags for later service.
// R10 - Software re-sets the global enable for nesting.
// R11 - Full stack defers every request until a pop.
// R12 - Simultaneous enabled requests served in fixed priority order.
// R13 - A flag becoming set wakes the core from sleep or idle.
// R14 - Each external pin sets its flag on the selected edge.
// R15 - Pin acts only if enabled, function selected and input.
// R16 - Edge control: rising, falling, both, or disabled.
// R17 - Servicing an external interrupt clears its flag.
// R18 - Comparator output change sets flag; service clears it.
// R19 - Five multi-function groups collect member requests.
// R20 - Any member request sets its group flag.
// R21 - Group service clears only group flag; members stay set.
// R22 - Conversion done sets flag; service clears it.
// R23 - Vectors and priority order are implementation parameters.

module mic_ctrl #(
  parameter int              PC_W       = 16,
  parameter int              DEPTH      = 8,
  parameter logic [PC_W-1:0] VEC_BASE   = 16'h0004,
  parameter logic [PC_W-1:0] VEC_STRIDE = 16'h0004
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // Register port
  input  wire mic_pkg::mic_bus_req_type bus_req,
  output logic [mic_pkg::DW-1:0]     rd_data_r,
  // External pins and their pin setup
  input  wire logic [mic_pkg::NEXT-1:0] ext_irq_pins,
  input  wire logic [mic_pkg::NEXT-1:0] ext_pin_func_sel,
  input  wire logic [mic_pkg::NEXT-1:0] ext_port_dir_in,
  // Internal sources
  input  wire logic [mic_pkg::NCMP-1:0]  cmp_out,
  input  wire logic                      conv_done,
  input  wire logic [mic_pkg::NGRP-1:0]  grp_member_req,
  input  wire logic [mic_pkg::NUART-1:0] uart_req,
  // Core side
  input  wire logic [PC_W-1:0]       next_pc,
  input  wire logic                  stack_push,
  input  wire logic                  stack_pop,
  input  wire logic                  return_from_interrupt_req,
  output logic                       pc_load_r,
  output logic [PC_W-1:0]            pc_value_r,
  output logic                       irq_taken_r,
  output logic [mic_pkg::SW-1:0]     taken_src_r,
  output logic                       wake_r
);

  localparam int NSRC = mic_pkg::NSRC;
  localparam int NEXT = mic_pkg::NEXT;
  localparam int NCMP = mic_pkg::NCMP;
  localparam int NGRP = mic_pkg::NGRP;
  localparam int NU   = mic_pkg::NUART;
  localparam int SW   = mic_pkg::SW;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic edge_hit(input logic [1:0] mode, input logic rise,
                                    input logic fall);
    case (mic_pkg::mic_edge_type'(mode))
      mic_pkg::MIC_EDGE_RISE: edge_hit = rise;
      mic_pkg::MIC_EDGE_FALL: edge_hit = fall;
      mic_pkg::MIC_EDGE_BOTH: edge_hit = rise | fall;
      default:                edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [SW-1:0] first_set(input logic [NSRC-1:0] v);
    first_set = '0;
    for (int i = NSRC - 1; i >= 0; i--)
      if (v[i])
        first_set = SW'(i);
  endfunction

  function automatic logic [PC_W-1:0] vec_addr(input logic [SW-1:0] idx);
    vec_addr = PC_W'(VEC_BASE + PC_W'(idx) * VEC_STRIDE);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [NEXT-1:0]   ext_s1_r, ext_s2_r, ext_s3_r, ext_lvl_r, ext_ok_r;
  logic [NEXT-1:0]   ext_flag_r, ext_en_r, ext_set, ext_flag_nxt;
  logic [2*NEXT-1:0] edge_sel_r;
  logic [NCMP-1:0]   cmp_prev_r, cmp_flag_r, cmp_en_r, cmp_set, cmp_flag_nxt;
  logic              cmp_ok_r;
  logic              conv_flag_r, conv_en_r, conv_flag_nxt;
  logic [NGRP-1:0]   grp_flag_r, grp_en_r, grp_set, grp_flag_nxt;
  logic [NU-1:0]     uart_flag_r, uart_en_r, uart_flag_nxt;
  logic              gie_r;
  logic [NSRC-1:0]   src_flag, src_en, pending, clr_vec;
  logic [SW-1:0]     win;
  logic              take, stk_full;
  logic [PC_W-1:0]   stk_top;
  logic              wr_ext, wr_cmp, wr_grpf, wr_uart, wr_ctrl;
  logic              new_set;
  logic [mic_pkg::DW-1:0] rd_nxt;

  assign wr_ctrl = bus_req.wr && bus_req.addr == mic_pkg::ADDR_CTRL;
  assign wr_ext  = bus_req.wr && bus_req.addr == mic_pkg::ADDR_EXT;
  assign wr_cmp  = bus_req.wr && bus_req.addr == mic_pkg::ADDR_CMP;
  assign wr_grpf = bus_req.wr && bus_req.addr == mic_pkg::ADDR_GRPF;
  assign wr_uart = bus_req.wr && bus_req.addr == mic_pkg::ADDR_UART;

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_s1_r  <= '0;
      ext_s2_r  <= '0;
      ext_s3_r  <= '0;
      ext_lvl_r <= '0;
      ext_ok_r  <= '0;
    end
    else
    begin
      ext_s1_r <= ext_irq_pins;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      for (int i = 0; i < NEXT; i++)
        if (ext_s2_r[i] == ext_s3_r[i])
        begin
          ext_lvl_r[i] <= ext_s3_r[i];
          ext_ok_r[i]  <= 1'b1;
        end
    end
  end

  // First settled level after reset only primes, never counts as an edge
  always_comb
  begin
    for (int i = 0; i < NEXT; i++)
      ext_set[i] = ext_ok_r[i] && ext_s2_r[i] == ext_s3_r[i]
                   && ext_en_r[i] && ext_pin_func_sel[i] && ext_port_dir_in[i] // R15
                   && edge_hit(edge_sel_r[2*i +: 2], ext_s3_r[i] & ~ext_lvl_r[i],
                               ~ext_s3_r[i] & ext_lvl_r[i]); // R14 R16
  end

  // ----------------------------------------
  // Source events
  // ----------------------------------------
  assign cmp_set = cmp_ok_r ? (cmp_out ^ cmp_prev_r) : '0; // R18

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cmp_prev_r <= '0;
      cmp_ok_r   <= 1'b0;
    end
    else
    begin
      cmp_prev_r <= cmp_out;
      cmp_ok_r   <= 1'b1;
    end
  end

  // Group flags follow member raises, whatever the member enables say
  always_comb
  begin
    grp_set = grp_member_req; // R19 R20
    grp_set[mic_pkg::UART_GROUP] = grp_member_req[mic_pkg::UART_GROUP] | (|uart_req); // R20
  end

  // ----------------------------------------
  // Priority and take decision
  // ----------------------------------------
  assign src_flag = {grp_flag_r, conv_flag_r, cmp_flag_r, ext_flag_r};
  assign src_en   = {grp_en_r, conv_en_r, cmp_en_r, ext_en_r};
  assign pending  = src_flag & src_en; // R4
  assign win      = first_set(pending); // R12 R23
  // Core stack traffic defers a take by a cycle to keep one stack user
  assign take     = gie_r && (|pending) && !stk_full // R5 R9 R11
                    && !stack_push && !stack_pop && !return_from_interrupt_req;
  assign clr_vec  = take ? (NSRC'(1) << win) : '0; // R17 R18 R21 R22

  // ----------------------------------------
  // Flag next values, set beats any clear
  // ----------------------------------------
  always_comb
  begin
    ext_flag_nxt  = ext_set | ((wr_ext ? bus_req.wdata[mic_pkg::EXT_FLAG_LSB +: NEXT]
                                       : ext_flag_r) & ~clr_vec[mic_pkg::SRC_EXT +: NEXT]);
    cmp_flag_nxt  = cmp_set | ((wr_cmp ? bus_req.wdata[mic_pkg::CMP_FLAG_LSB +: NCMP]
                                       : cmp_flag_r) & ~clr_vec[mic_pkg::SRC_CMP +: NCMP]);
    conv_flag_nxt = conv_done | ((wr_cmp ? bus_req.wdata[mic_pkg::CONV_FLAG_BIT]
                                         : conv_flag_r) & ~clr_vec[mic_pkg::SRC_CONV]); // R22
    grp_flag_nxt  = grp_set | ((wr_grpf ? bus_req.wdata[NGRP-1:0]
                                        : grp_flag_r) & ~clr_vec[mic_pkg::SRC_GRP +: NGRP]);
    // Member flags are never touched by a take
    uart_flag_nxt = uart_req | (wr_uart ? bus_req.wdata[mic_pkg::UART_FLAG_LSB +: NU]
                                        : uart_flag_r); // R21
  end

  assign new_set = |({ext_set, cmp_set, conv_done, grp_set, uart_req}
                     & ~{ext_flag_r, cmp_flag_r, conv_flag_r, grp_flag_r, uart_flag_r});

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_flag_r  <= '0;
      cmp_flag_r  <= '0;
      conv_flag_r <= mic_pkg::RST_BIT;
      grp_flag_r  <= '0;
      uart_flag_r <= '0;
    end
    else
    begin
      ext_flag_r  <= ext_flag_nxt; // R3
      cmp_flag_r  <= cmp_flag_nxt;
      conv_flag_r <= conv_flag_nxt;
      grp_flag_r  <= grp_flag_nxt;
      uart_flag_r <= uart_flag_nxt;
    end
  end

  // ----------------------------------------
  // Enables and edge control
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ext_en_r   <= '0;
      edge_sel_r <= mic_pkg::RST_BYTE;
      cmp_en_r   <= '0;
      conv_en_r  <= mic_pkg::RST_BIT;
      grp_en_r   <= '0;
      uart_en_r  <= '0;
    end
    else if (bus_req.wr)
    begin
      case (bus_req.addr)
        mic_pkg::ADDR_EXT:  ext_en_r   <= bus_req.wdata[mic_pkg::EXT_EN_LSB +: NEXT];
        mic_pkg::ADDR_EDGE: edge_sel_r <= bus_req.wdata;
        mic_pkg::ADDR_CMP:
        begin
          cmp_en_r  <= bus_req.wdata[mic_pkg::CMP_EN_LSB +: NCMP];
          conv_en_r <= bus_req.wdata[mic_pkg::CONV_EN_BIT];
        end
        mic_pkg::ADDR_GRPE: grp_en_r   <= bus_req.wdata[NGRP-1:0];
        mic_pkg::ADDR_UART: uart_en_r  <= bus_req.wdata[mic_pkg::UART_EN_LSB +: NU]; // R2
        default:            ;
      endcase
    end
  end

  // Hardware clear on take wins over a software set in the same cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      gie_r <= mic_pkg::RST_BIT;
    else if (take)
      gie_r <= 1'b0; // R8
    else if (wr_ctrl)
      gie_r <= bus_req.wdata[mic_pkg::CTRL_GIE_BIT]; // R10
  end

  // ----------------------------------------
  // Return address stack
  // ----------------------------------------
  mic_stack #(
    .PC_W  (PC_W),
    .DEPTH (DEPTH)
  ) u_stack (
    .clk       (clk),
    .arst_n    (arst_n),
    .push      (take | stack_push),
    .pop       (stack_pop | return_from_interrupt_req),
    .push_data (next_pc),
    .top_data  (stk_top),
    .full      (stk_full)
  );

  // ----------------------------------------
  // Program counter load and status outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pc_load_r   <= 1'b0;
      pc_value_r  <= '0;
      irq_taken_r <= 1'b0;
      taken_src_r <= '0;
      wake_r      <= 1'b0;
    end
    else
    begin
      pc_load_r   <= take | return_from_interrupt_req;
      irq_taken_r <= take;
      wake_r      <= new_set; // R13
      if (take)
      begin
        pc_value_r  <= vec_addr(win); // R6
        taken_src_r <= win;
      end
      else if (return_from_interrupt_req)
        pc_value_r <= stk_top; // R7
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_comb
  begin
    rd_nxt = mic_pkg::RST_BYTE;
    case (bus_req.addr)
      mic_pkg::ADDR_CTRL:
      begin
        rd_nxt[mic_pkg::CTRL_GIE_BIT]  = gie_r;
        rd_nxt[mic_pkg::CTRL_FULL_BIT] = stk_full;
      end
      mic_pkg::ADDR_EXT:
      begin
        rd_nxt[mic_pkg::EXT_FLAG_LSB +: NEXT] = ext_flag_r;
        rd_nxt[mic_pkg::EXT_EN_LSB +: NEXT]   = ext_en_r;
      end
      mic_pkg::ADDR_EDGE: rd_nxt = edge_sel_r;
      mic_pkg::ADDR_CMP:
      begin
        rd_nxt[mic_pkg::CMP_FLAG_LSB +: NCMP] = cmp_flag_r;
        rd_nxt[mic_pkg::CONV_FLAG_BIT]        = conv_flag_r;
        rd_nxt[mic_pkg::CMP_EN_LSB +: NCMP]   = cmp_en_r;
        rd_nxt[mic_pkg::CONV_EN_BIT]          = conv_en_r;
      end
      mic_pkg::ADDR_GRPF: rd_nxt[NGRP-1:0] = grp_flag_r;
      mic_pkg::ADDR_GRPE: rd_nxt[NGRP-1:0] = grp_en_r;
      mic_pkg::ADDR_UART:
      begin
        rd_nxt[mic_pkg::UART_FLAG_LSB +: NU] = uart_flag_r; // R1
        rd_nxt[mic_pkg::UART_EN_LSB +: NU]   = uart_en_r;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_data_r <= mic_pkg::RST_BYTE;
    else
      rd_data_r <= bus_req.rd ? rd_nxt : mic_pkg::RST_BYTE;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_take;
    take ##0 (win == first_set(pending));
  endsequence

  sequence s_vector_out;
    pc_load_r && irq_taken_r && !gie_r && pc_value_r == vec_addr($past(win));
  endsequence

  uart_reserved_a: assert property ( // R1
    bus_req.rd && bus_req.addr == mic_pkg::ADDR_UART |=> rd_data_r[7] == 1'b0
    && rd_data_r[3] == 1'b0 && rd_data_r[6:4] == $past(uart_flag_r))
    else $error("UART register reserved bits or flags wrong");

  uart_enable_a: assert property ( // R2
    wr_uart |=> uart_en_r == $past(bus_req.wdata[2:0]))
    else $error("UART enables not written");

  conv_set_a: assert property ( // R3
    conv_done |=> conv_flag_r)
    else $error("Conversion flag not set");

  disabled_hold_a: assert property ( // R4
    cmp_flag_r[0] && !cmp_en_r[0] && !wr_cmp |=> cmp_flag_r[0])
    else $error("Disabled flag lost");

  gie_block_a: assert property ( // R5
    !gie_r |-> !take)
    else $error("Interrupt taken with global enable low");

  take_vector_a: assert property ( // R6
    s_take |=> s_vector_out)
    else $error("Take did not load vector and clear global enable");

  return_from_interrupt_pop_a: assert property ( // R7
    return_from_interrupt_req |=> pc_load_r && !irq_taken_r && pc_value_r == $past(stk_top))
    else $error("Return did not restore PC");

  full_defer_a: assert property ( // R11
    stk_full |-> !take)
    else $error("Interrupt taken with full stack");

  priority_a: assert property ( // R12
    take |-> (pending & ((NSRC'(1) << win) - NSRC'(1))) == '0)
    else $error("Lower priority source taken first");

  wake_a: assert property ( // R13
    conv_done && !conv_flag_r |=> wake_r)
    else $error("Flag set without wake");

  ext_clear_a: assert property ( // R17
    take && win < SW'(NEXT) && (ext_set & clr_vec[mic_pkg::SRC_EXT +: NEXT]) == '0
    |=> (ext_flag_r & $past(clr_vec[mic_pkg::SRC_EXT +: NEXT])) == '0)
    else $error("External flag not cleared on service");

  group_keep_a: assert property ( // R21
    take && win == SW'(mic_pkg::SRC_GRP + mic_pkg::UART_GROUP) && !wr_uart
    |=> uart_flag_r == ($past(uart_flag_r) | $past(uart_req))
        && (!grp_flag_r[mic_pkg::UART_GROUP] || $past(grp_set[mic_pkg::UART_GROUP])))
    else $error("Group service touched member flags");

endmodule

// ==== verif/mic_ctrl_tb.sv ====
// Purpose: Self-checking bench of the interrupt controller.
// Assumes: Inputs move by non-blocking writes at rising clk edges.
// Notes:   Stack depth cut to 4 so the full-stack case stays short.

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module mic_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int          D  = 4;
  localparam logic [15:0] VB = 16'h0004;
  localparam logic [15:0] VS = 16'h0004;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                     clk, arst_n, conv_done, stack_push, stack_pop, return_from_interrupt_req;
  logic                     pc_load_r, irq_taken_r, wake_r;
  mic_pkg::mic_bus_req_type bus_req;
  logic [7:0]               rd_data_r, rv;
  logic [3:0]               ext_irq_pins, ext_pin_func_sel, ext_port_dir_in, taken_src_r;
  logic [1:0]               cmp_out;
  logic [4:0]               grp_member_req;
  logic [2:0]               uart_req;
  logic [15:0]              next_pc, pc_value_r;
  int                       n_mismatch, n_compared, n_take, n_wake, t0, w0, u;

  mic_ctrl #(.DEPTH(D), .VEC_BASE(VB), .VEC_STRIDE(VS)) i_mic_ctrl (
    .clk(clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data_r(rd_data_r),
    .ext_irq_pins(ext_irq_pins), .ext_pin_func_sel(ext_pin_func_sel),
    .ext_port_dir_in(ext_port_dir_in), .cmp_out(cmp_out), .conv_done(conv_done),
    .grp_member_req(grp_member_req), .uart_req(uart_req), .next_pc(next_pc),
    .stack_push(stack_push), .stack_pop(stack_pop), .return_from_interrupt_req(return_from_interrupt_req),
    .pc_load_r(pc_load_r), .pc_value_r(pc_value_r), .irq_taken_r(irq_taken_r),
    .taken_src_r(taken_src_r), .wake_r(wake_r));

  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // Pulse counters, so silent stretches can be checked afterwards
  always @(posedge clk)
  begin
    if (irq_taken_r === 1'h1) n_take <= n_take + 1;
    if (wake_r === 1'h1) n_wake <= n_wake + 1;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Trailing idle cycle keeps the strobe from being driven twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus_req <= {1'h1, 1'h0, a, d};
    cyc(1);
    bus_req <= '0;
    cyc(1);
  endtask

  task automatic chkrd(input logic [3:0] a, input logic [7:0] e);
    bus_req <= {1'h0, 1'h1, a, 8'h00};
    cyc(1);
    bus_req <= '0;
    cyc(1);
    `CHK($sformatf("reg %0h", a), e, rd_data_r)
  endtask

  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Waits for a take, checks the vector, then returns and checks the pop
  task automatic take(input int s);
    logic [15:0] ret;
    int          i;
    ret = next_pc;
    i = 0;
    while (irq_taken_r !== 1'h1 && i < 20)
    begin
      cyc(1);
      i++;
    end
    if (i == 20)
    begin
      n_mismatch++;
      $display("MISMATCH take of source %0d exp 1 got 0", s);
      final_report();
    end
    `CHK("pc load", 1'h1, pc_load_r)
    `CHK("vector", VB + VS * 16'(s), pc_value_r)
    `CHK("source", 4'(s), taken_src_r)
    cyc(1);
    return_from_interrupt_req <= 1'h1;
    cyc(1);
    return_from_interrupt_req <= 1'h0;
    cyc(1);
    `CHK("return pc", ret, pc_value_r)
    `CHK("return load", 1'h1, pc_load_r)
  endtask

  function automatic logic [7:0] xe(input int p, input logic [1:0] m, input logic r);
    logic h;
    h = (m == 2'h3) || (r ? m == 2'h1 : m == 2'h2);
    return ({7'h00, h} << (4 + p)) | (8'h01 << p);
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {arst_n, conv_done, stack_push, stack_pop, return_from_interrupt_req} = '0;
    {ext_irq_pins, ext_pin_func_sel, ext_port_dir_in, cmp_out} = '0;
    {grp_member_req, uart_req, next_pc, bus_req} = '0;
    {n_mismatch, n_compared} = '0;
    void'($urandom(55327));
    cyc(10);
    arst_n <= 1'h1;
    for (int a = 0; a < 16; a++)
      chkrd(a[3:0], 8'h00);
    for (int a = 7; a < 16; a++)
    begin
      wr(a[3:0], 8'hFF);
      chkrd(a[3:0], 8'h00);
    end
    for (int i = 0; i < 5; i++)
    begin
      rv = (i == 0) ? 8'hFF : 8'($urandom());
      wr(mic_pkg::ADDR_UART, rv);
      chkrd(mic_pkg::ADDR_UART, rv & 8'h77);
    end
    $display("test registers done");

    wr(mic_pkg::ADDR_CMP, 8'h04);
    t0 = n_take;
    w0 = n_wake;
    for (int i = 0; i < 2; i++)
    begin
      conv_done <= 1'h1;
      cyc(1);
      conv_done <= 1'h0;
      cyc(3);
      chkrd(mic_pkg::ADDR_CMP, 8'h44);
      `CHK("wake count", w0 + 1, n_wake)
    end
    `CHK("take count", t0, n_take)
    next_pc <= 16'($urandom());
    wr(mic_pkg::ADDR_CTRL, 8'h01);
    take(6);
    chkrd(mic_pkg::ADDR_CMP, 8'h04);
    chkrd(mic_pkg::ADDR_CTRL, 8'h00);
    wr(mic_pkg::ADDR_CMP, 8'h40);
    t0 = n_take;
    wr(mic_pkg::ADDR_CTRL, 8'h01);
    cyc(10);
    `CHK("take count", t0, n_take)
    chkrd(mic_pkg::ADDR_CMP, 8'h40);
    wr(mic_pkg::ADDR_CTRL, 8'h00);
    wr(mic_pkg::ADDR_CMP, 8'h77);
    rv = 8'h77;
    for (int k = 0; k < 3; k++)
    begin
      next_pc <= 16'($urandom());
      wr(mic_pkg::ADDR_CTRL, 8'h01);
      take(4 + k);
      rv[4 + k] = 1'h0;
      chkrd(mic_pkg::ADDR_CMP, rv);
    end
    cmp_out <= 2'($urandom());
    cyc(3);
    wr(mic_pkg::ADDR_CMP, 8'h00);
    cmp_out <= cmp_out ^ 2'h1;
    cyc(3);
    chkrd(mic_pkg::ADDR_CMP, 8'h10);
    cmp_out <= cmp_out ^ 2'h2;
    cyc(3);
    chkrd(mic_pkg::ADDR_CMP, 8'h30);
    $display("test internal sources done");

    ext_pin_func_sel <= 4'hF;
    ext_port_dir_in <= 4'hF;
    for (int p = 0; p < 4; p++)
      for (int m = 0; m < 4; m++)
      begin
        wr(mic_pkg::ADDR_EXT, 8'h01 << p);
        wr(mic_pkg::ADDR_EDGE, 8'(m << (2 * p)));
        ext_irq_pins[p] <= 1'h1;
        cyc(8);
        chkrd(mic_pkg::ADDR_EXT, xe(p, 2'(m), 1'h1));
        wr(mic_pkg::ADDR_EXT, 8'h01 << p);
        ext_irq_pins[p] <= 1'h0;
        cyc(8);
        chkrd(mic_pkg::ADDR_EXT, xe(p, 2'(m), 1'h0));
      end
    wr(mic_pkg::ADDR_EDGE, 8'h03);
    for (int c = 0; c < 3; c++)
    begin
      wr(mic_pkg::ADDR_EXT, {7'h00, c != 0});
      ext_pin_func_sel[0] <= (c != 1);
      ext_port_dir_in[0] <= (c != 2);
      cyc(4);
      ext_irq_pins[0] <= ~ext_irq_pins[0];
      cyc(8);
      chkrd(mic_pkg::ADDR_EXT, {7'h00, c != 0});
    end
    wr(mic_pkg::ADDR_EDGE, 8'hC0);
    wr(mic_pkg::ADDR_EXT, 8'h08);
    ext_irq_pins[3] <= 1'h1;
    cyc(8);
    next_pc <= 16'($urandom());
    wr(mic_pkg::ADDR_CTRL, 8'h01);
    take(3);
    chkrd(mic_pkg::ADDR_EXT, 8'h08);
    $display("test external pins done");

    for (int g = 0; g < 5; g++)
    begin
      wr(mic_pkg::ADDR_GRPF, 8'h00);
      grp_member_req[g] <= 1'h1;
      cyc(1);
      grp_member_req[g] <= 1'h0;
      cyc(3);
      chkrd(mic_pkg::ADDR_GRPF, 8'h01 << g);
    end
    wr(mic_pkg::ADDR_GRPF, 8'h00);
    wr(mic_pkg::ADDR_UART, 8'h00);
    u = $urandom_range(2);
    uart_req[u] <= 1'h1;
    cyc(1);
    uart_req <= 3'h0;
    cyc(3);
    chkrd(mic_pkg::ADDR_UART, 8'h10 << u);
    chkrd(mic_pkg::ADDR_GRPF, 8'h10);
    wr(mic_pkg::ADDR_GRPE, 8'h10);
    wr(mic_pkg::ADDR_CTRL, 8'h01);
    take(11);
    chkrd(mic_pkg::ADDR_GRPF, 8'h00);
    chkrd(mic_pkg::ADDR_UART, 8'h10 << u);
    $display("test groups done");

    repeat (D)
    begin
      stack_push <= 1'h1;
      cyc(1);
      stack_push <= 1'h0;
      cyc(1);
    end
    chkrd(mic_pkg::ADDR_CTRL, 8'h02);
    wr(mic_pkg::ADDR_CMP, 8'h11);
    t0 = n_take;
    wr(mic_pkg::ADDR_CTRL, 8'h01);
    cyc(10);
    `CHK("take count", t0, n_take)
    chkrd(mic_pkg::ADDR_CTRL, 8'h03);
    stack_pop <= 1'h1;
    cyc(1);
    stack_pop <= 1'h0;
    take(4);
    $display("test full stack done");
    final_report();
  end
endmodule
